// ==== design/asp_regs.svh ====
// Bit counts, trim window layout and reset values of the serial port
`ifndef ASP_REGS_SVH
`define ASP_REGS_SVH
`define ASP_HDR_BITS 5'h10
`define ASP_FRAME_BITS 5'h18
`define ASP_CNT_STEP 5'h01
`define ASP_CNT_RESET 5'h00
`define ASP_ADDR_STEP 15'h0001
`define ASP_ADDR_RESET 15'h0000
`define ASP_OP_BIT 15
`define ASP_ADDR_HI 14
`define ASP_DATA_HI 7
`define ASP_WIN_LO 6
`define ASP_IDX_HI 5
`define ASP_TRIM_BASE 9'h008
`define ASP_TRIM_BYTES 64
`define ASP_NUM_CORES 6
`define ASP_NUM_INPUTS 4
`define ASP_BANDGAP_TRIM 6'h00
`define ASP_TERM_TRIM 6'h01
`define ASP_OFFSET_TRIM 6'h08
`define ASP_GAIN_TRIM 6'h18
`define ASP_FS_TRIM 6'h30
`define ASP_TRIM_RESET 8'h00
`define ASP_PIN_IDLE 3'h2
`endif

// ==== design/asp_pkg.sv ====
// Types shared by the serial register port and its helpers
package asp_pkg;
`include "asp_regs.svh"

typedef enum logic [1:0]
{
    ASP_IDLE = 2'b00,
    ASP_HDR = 2'b01,
    ASP_DATA = 2'b11
} asp_phase_e;

typedef struct packed
{
    logic sclk;
    logic select_n;
    logic data_in;
} asp_pin_in_s;

typedef struct packed
{
    logic serial_data_out;
    logic serial_data_oe_n;
} asp_pin_out_s;

typedef struct packed
{
    logic we;
    logic [5:0] addr;
    logic [7:0] data;
} asp_host_wr_s;

typedef struct packed
{
    logic we;
    logic [2:0] core;
    logic [15:0] value;
} asp_cal_wr_s;

typedef logic [`ASP_TRIM_BYTES-1:0][7:0] asp_trim_bytes_t;

typedef struct packed
{
    logic [7:0] bandgap_trim;
    logic [`ASP_NUM_INPUTS-1:0][7:0] termination_trim;
    logic [`ASP_NUM_CORES-1:0][15:0] core_offset_trim;
    logic [`ASP_NUM_CORES-1:0][15:0] core_gain_trim;
    logic [15:0] full_scale_adjust;
} asp_trim_s;

endpackage

// ==== design/asp_pin_sync.sv ====
// Three-stage synchroniser with agreement filter for the serial pins
`timescale 1ns/1ns
`include "asp_regs.svh"
module asp_pin_sync
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input asp_pkg::asp_pin_in_s pin_raw,
    output asp_pkg::asp_pin_in_s pin_clean
);
import asp_pkg::*;

typedef struct packed
{
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    logic [2:0] clean;
} asp_sync_state_s;

asp_sync_state_s st;
asp_sync_state_s next_st;

always_comb
begin
    next_st = st;
    next_st.s1 = pin_raw;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    // A level counts only once stages two and three agree
    next_st.clean = (st.s2 & st.s3) | (st.clean & (st.s2 | st.s3));
end

always_ff @(posedge clk_sys)
begin
    if (!rst_b)
    begin
        st <= {4{`ASP_PIN_IDLE}};
    end
    else
    begin
        st <= next_st;
    end
end

assign pin_clean = st.clean;

endmodule // asp_pin_sync

// ==== design/asp_trim_mem.sv ====
// Byte-wide trim register store with registered read port
`timescale 1ns/1ns
`include "asp_regs.svh"
module asp_trim_mem
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input asp_pkg::asp_host_wr_s host_wr,
    input asp_pkg::asp_cal_wr_s cal_wr,
    input wire logic [5:0] rd_addr,
    output logic [7:0] rd_data,
    output asp_pkg::asp_trim_bytes_t trim_bytes
);
import asp_pkg::*;

typedef struct packed
{
    asp_trim_bytes_t mem;
    logic [7:0] rd_data;
} asp_mem_state_s;

asp_mem_state_s st;
asp_mem_state_s next_st;
logic [5:0] cal_idx;

always_comb
begin
    next_st = st;
    cal_idx = 6'(`ASP_OFFSET_TRIM + {2'b00, cal_wr.core, 1'b0});
    next_st.rd_data = st.mem[rd_addr];
    if (host_wr.we)
    begin
        next_st.mem[host_wr.addr] = host_wr.data;
    end
    // Calibration reaches only the offset bytes; gain trims stay put
    if (cal_wr.we && (cal_wr.core < 3'(`ASP_NUM_CORES))) // [RULE17]
    begin
        // Calibration owns the offsets and wins a same-cycle clash
        next_st.mem[cal_idx] = cal_wr.value[7:0]; // [RULE22]
        next_st.mem[cal_idx + 6'h01] = cal_wr.value[15:8]; // [RULE18]
    end
end

always_ff @(posedge clk_sys)
begin
    if (!rst_b)
    begin
        st <= {{`ASP_TRIM_BYTES{`ASP_TRIM_RESET}}, `ASP_TRIM_RESET};
    end
    else
    begin
        st <= next_st;
    end
end

assign rd_data = st.rd_data;
assign trim_bytes = st.mem;

endmodule // asp_trim_mem

// ==== design/asp_serial_port.sv ====
// Serial register access port with the converter trim register group
// Summary of operation
// (RULE1) Select low frames an access; serial activity while high is ignored.
// (RULE2) Input bits are sampled on rising serial clock edges.
// (RULE3) No timeout: any slow or stalled serial clock works.
// (RULE4) A single access is 24 serial clocks from chip select assertion.
// (RULE5) First bit chooses the operation: one reads, zero writes.
// (RULE6) Next 15 bits are the register address, MSB first.
// (RULE7) A write stores the final eight bits into the addressed register.
// (RULE8) A read ignores the last eight input bits and shifts register out.
// (RULE9) Output is undriven in writes and in read header phases.
// (RULE10) Every field travels most significant bit first.
// (RULE11) Multi-byte registers are little-endian, low byte at low address.
// (RULE12) Further bytes follow in the same direction while select stays low.
// (RULE13) Streaming moves the address by one per byte; increment by default.
// (RULE14) Direction bit selects an upward or downward address step.
// (RULE15) Address hold bit stops the address from advancing.
// (RULE16) Host issues no access while converter calibration runs.
// (RULE17) Calibration never modifies the per-core gain trims.
// (RULE18) Each converter core has its own offset trim value.
// (RULE19) One full-scale setting for all inputs; matching via gain trims.
// (RULE20) Offset and background calibration on: offset registers feed trims.
// (RULE21) Termination trimming valid only when powered and clocked.
// (RULE22) Software leaves offset trims alone while calibration owns them.
// (RULE23) Select release ends the access; a partial write is dropped.
`timescale 1ns/1ns
`include "asp_regs.svh"
module asp_serial_port
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input asp_pkg::asp_pin_in_s pin_in,
    output asp_pkg::asp_pin_out_s pin_out,
    input wire logic addr_step_up,
    input wire logic addr_hold,
    input wire logic fg_offset_cal_enable,
    input wire logic background_cal_enable,
    input asp_pkg::asp_cal_wr_s cal_wr,
    output asp_pkg::asp_trim_s trims,
    output logic offset_trim_from_regs,
    output logic xfer_active,
    output logic write_done,
    output logic write_aborted
);
import asp_pkg::*;

typedef struct packed
{
    asp_phase_e phase;
    logic prev_sclk;
    logic [4:0] cnt;
    logic [15:0] shift_in;
    logic read_op;
    logic [14:0] addr;
    logic rd_hit;
    logic [7:0] out_shift;
    logic drive;
    logic offset_src;
    logic active;
    logic wr_done;
    logic wr_abort;
} asp_state_s;

asp_state_s st;
asp_state_s next_st;
asp_pin_in_s pc;
asp_host_wr_s host_wr;
asp_trim_bytes_t trim_bytes;
logic [7:0] rd_data;
logic [7:0] rd_byte;
logic sclk_rise;
logic sclk_fall;
logic [`ASP_NUM_INPUTS-1:0][7:0] term_w;
logic [`ASP_NUM_CORES-1:0][15:0] offset_w;
logic [`ASP_NUM_CORES-1:0][15:0] gain_w;

asp_pin_sync u_sync
(
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .pin_raw(pin_in),
    .pin_clean(pc)
);

asp_trim_mem u_mem
(
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .host_wr(host_wr),
    .cal_wr(cal_wr),
    .rd_addr(st.addr[`ASP_IDX_HI:0]),
    .rd_data(rd_data),
    .trim_bytes(trim_bytes)
);

// Edges come from the filtered level; nothing counts time between them
assign sclk_rise = pc.sclk & ~st.prev_sclk; // [RULE2] [RULE3]
assign sclk_fall = ~pc.sclk & st.prev_sclk;
// Addresses outside the trim window read as zero
assign rd_byte = st.rd_hit ? rd_data : 8'h00;

always_comb
begin
    next_st = st;
    host_wr = '0;
    next_st.prev_sclk = pc.sclk;
    next_st.wr_done = 1'b0;
    next_st.wr_abort = 1'b0;
    next_st.rd_hit = (st.addr[`ASP_ADDR_HI:`ASP_WIN_LO] == `ASP_TRIM_BASE);
    next_st.offset_src = fg_offset_cal_enable
        & background_cal_enable; // [RULE20]
    next_st.active = ~pc.select_n;
    if (pc.select_n) // [RULE1]
    begin
        // Half-received write bytes never reach the store
        next_st.wr_abort = (st.phase != ASP_IDLE) && !st.read_op
            && (st.cnt != `ASP_HDR_BITS); // [RULE23]
        next_st.phase = ASP_IDLE;
        next_st.cnt = `ASP_CNT_RESET; // [RULE23]
        next_st.read_op = 1'b0;
        next_st.drive = 1'b0;
    end
    else
    begin
        if (sclk_rise)
        begin
            next_st.shift_in = {st.shift_in[14:0], pc.data_in}; // [RULE10]
            next_st.cnt = st.cnt + `ASP_CNT_STEP;
            unique case (st.phase)
                ASP_IDLE, ASP_HDR:
                begin
                    next_st.phase = ASP_HDR;
                    if (next_st.cnt == `ASP_HDR_BITS)
                    begin
                        next_st.phase = ASP_DATA;
                        next_st.read_op =
                            next_st.shift_in[`ASP_OP_BIT]; // [RULE5]
                        next_st.addr =
                            next_st.shift_in[`ASP_ADDR_HI:0]; // [RULE6]
                    end
                end
                ASP_DATA:
                begin
                    // Byte boundary at bit 24 and every eight bits after
                    if (next_st.cnt == `ASP_FRAME_BITS) // [RULE4] [RULE12]
                    begin
                        if (!st.read_op)
                        begin
                            host_wr.we = st.rd_hit; // [RULE7]
                            host_wr.addr = st.addr[`ASP_IDX_HI:0];
                            host_wr.data = next_st.shift_in[`ASP_DATA_HI:0];
                            next_st.wr_done = 1'b1;
                        end
                        next_st.cnt = `ASP_HDR_BITS; // [RULE12]
                        if (!addr_hold) // [RULE15]
                        begin
                            if (addr_step_up) // [RULE13] [RULE14]
                            begin
                                next_st.addr = st.addr + `ASP_ADDR_STEP;
                            end
                            else
                            begin
                                next_st.addr = st.addr - `ASP_ADDR_STEP;
                            end
                        end
                    end
                end
            endcase
        end
        // Read data leaves on falling edges so the host samples it rising;
        // input bits of the data phase are shifted but never used
        if (sclk_fall && (st.phase == ASP_DATA) && st.read_op) // [RULE8]
        begin
            if (st.cnt == `ASP_HDR_BITS)
            begin
                next_st.out_shift = rd_byte;
                next_st.drive = 1'b1; // [RULE9]
            end
            else
            begin
                next_st.out_shift = {st.out_shift[6:0], 1'b0}; // [RULE10]
            end
        end
    end
end

always_ff @(posedge clk_sys)
begin
    if (!rst_b)
    begin
        st <= '{phase: ASP_IDLE, prev_sclk: 1'b0, cnt: `ASP_CNT_RESET,
            shift_in: 16'h0000, read_op: 1'b0, addr: `ASP_ADDR_RESET,
            rd_hit: 1'b0, out_shift: 8'h00, drive: 1'b0, offset_src: 1'b0,
            active: 1'b0, wr_done: 1'b0, wr_abort: 1'b0};
    end
    else
    begin
        st <= next_st;
    end
end

// Multi-byte trims are little-endian across consecutive bytes
genvar k;
generate
    for (k = 0; k < `ASP_NUM_CORES; k++)
    begin : g_core
        assign offset_w[k] = {trim_bytes[`ASP_OFFSET_TRIM + 2 * k + 1],
            trim_bytes[`ASP_OFFSET_TRIM + 2 * k]}; // [RULE11] [RULE18]
        assign gain_w[k] = {trim_bytes[`ASP_GAIN_TRIM + 2 * k + 1],
            trim_bytes[`ASP_GAIN_TRIM + 2 * k]}; // [RULE11]
        if (k < `ASP_NUM_INPUTS)
        begin : g_term
            assign term_w[k] = trim_bytes[`ASP_TERM_TRIM + k];
        end
    end
endgenerate

// One full-scale word serves all inputs; per-core gains do the matching
assign trims = '{bandgap_trim: trim_bytes[`ASP_BANDGAP_TRIM],
    termination_trim: term_w,
    core_offset_trim: offset_w,
    core_gain_trim: gain_w,
    full_scale_adjust: {trim_bytes[`ASP_FS_TRIM + 1],
        trim_bytes[`ASP_FS_TRIM]}}; // [RULE19]

assign pin_out.serial_data_out = st.out_shift[7];
assign pin_out.serial_data_oe_n = ~st.drive; // [RULE9]
assign offset_trim_from_regs = st.offset_src;
assign xfer_active = st.active;
assign write_done = st.wr_done;
assign write_aborted = st.wr_abort;

endmodule // asp_serial_port

// ==== test/asp_serial_port_props.sv ====
// Concurrent checks on the serial register port outputs
`timescale 1ns/1ns
module asp_serial_port_props
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input asp_pkg::asp_pin_in_s pin_in,
    input asp_pkg::asp_pin_out_s pin_out,
    input wire logic addr_step_up,
    input wire logic addr_hold,
    input wire logic fg_offset_cal_enable,
    input wire logic background_cal_enable,
    input asp_pkg::asp_cal_wr_s cal_wr,
    input asp_pkg::asp_trim_s trims,
    input wire logic offset_trim_from_regs,
    input wire logic xfer_active,
    input wire logic write_done,
    input wire logic write_aborted
);
import asp_pkg::*;
default clocking cb @(posedge clk_sys); endclocking
default disable iff (!rst_b);
AST_OE_IDLE: assert property
    (!xfer_active ##1 !xfer_active |-> pin_out.serial_data_oe_n)
    else $error("Output driven outside an access");
AST_WR_UNDRIVEN: assert property
    (write_done |-> pin_out.serial_data_oe_n)
    else $error("Output driven during a write");
AST_WR_FRAMED: assert property (write_done |-> $past(xfer_active))
    else $error("Write completed outside a select frame");
AST_WR_PULSE: assert property (write_done |=> !write_done)
    else $error("Write completion longer than one cycle");
AST_DONE_ABORT: assert property (!(write_done && write_aborted))
    else $error("Write both completed and dropped");
AST_OFFSET_SRC: assert property ($past(rst_b) |->
    offset_trim_from_regs == $past(fg_offset_cal_enable
    && background_cal_enable))
    else $error("Offset source select wrong");
AST_CAL_OFFSET: assert property (cal_wr.we && cal_wr.core < 3'h6
    |=> trims.core_offset_trim[$past(cal_wr.core)] == $past(cal_wr.value))
    else $error("Calibration offset not stored for its core");
AST_GAIN_KEPT: assert property (cal_wr.we |=>
    $stable(trims.core_gain_trim) && $stable(trims.full_scale_adjust))
    else $error("Calibration disturbed gain or range trims");
cover property (write_done);
cover property ($fell(pin_out.serial_data_oe_n));
cover property (write_aborted);
cover property (offset_trim_from_regs);
endmodule // asp_serial_port_props

// ==== test/asp_host_model.sv ====
// Serial host that frames register accesses for the port
`timescale 1ns/1ns
module asp_host_model
(
    output logic sclk,
    output logic select_n,
    output logic data_in,
    input wire logic serial_data_out,
    input wire logic serial_data_oe_n
);
wire line_out = serial_data_oe_n ? 1'bz : serial_data_out;
initial
begin
    sclk = 1'b0;
    select_n = 1'b1;
    data_in = 1'b0;
end
// Read bits are taken late in the high phase: output moves after a fall
task automatic xfer(input logic rd, input logic [14:0] addr, input int nbits,
    input int slow, input logic [31:0] wd, output logic [31:0] rq);
    logic [47:0] fr;
    begin
        fr = {rd, addr, wd[7:0], wd[15:8], wd[23:16], wd[31:24]};
        rq = '0;
        select_n = 1'b0;
        for (int i = 0; i < nbits; i++)
        begin
            data_in = fr[47 - i];
            #(16 + 4 * slow);
            sclk = 1'b1;
            #12;
            if (i >= 16)
                rq[8 * ((i - 16) / 8) + 7 - (i - 16) % 8] = line_out;
            #4;
            sclk = 1'b0;
        end
        #16;
        select_n = 1'b1;
        data_in = ~data_in; // Released line must not hold its level
        #32;
    end
endtask
task automatic noise();
    for (int i = 0; i < 24; i++)
    begin
        data_in = ~data_in;
        #16;
        sclk = 1'b1;
        #16;
        sclk = 1'b0;
    end
endtask
endmodule // asp_host_model

// ==== test/asp_serial_port_tb.sv ====
// Self-checking bench for the serial register port
`timescale 1ns/1ns
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_fail++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module asp_serial_port_tb;
import asp_pkg::*;
logic clk_sys = 1'b0;
logic rst_b = 1'b0;
wire sclk_pin;
wire select_n_pin;
wire data_in_pin;
asp_pin_in_s pin_in;
asp_pin_out_s pin_out;
logic addr_step_up = 1'b1;
logic addr_hold = 1'b0;
logic fg_offset_cal_enable = 1'b0;
logic background_cal_enable = 1'b0;
asp_cal_wr_s cal_wr = '0;
asp_trim_s trims;
logic offset_trim_from_regs;
logic xfer_active;
logic write_done;
logic write_aborted;
logic [31:0] rq;
int n_fail = 0;
int total_checks = 0;
int n_wdone = 0;
int n_abort = 0;
int n_active = 0;
// Pulses are counted on the falling edge, where they have settled
always @(negedge clk_sys)
begin
    if (write_done === 1'b1)
        n_wdone++;
    if (write_aborted === 1'b1)
        n_abort++;
    if (xfer_active === 1'b1)
        n_active++;
end
assign pin_in = {sclk_pin, select_n_pin, data_in_pin};
always #2 clk_sys = ~clk_sys;
asp_host_model u_asp_host_model (.sclk(sclk_pin), .select_n(select_n_pin),
    .data_in(data_in_pin), .serial_data_out(pin_out.serial_data_out),
    .serial_data_oe_n(pin_out.serial_data_oe_n));
asp_serial_port u_asp_serial_port (.clk_sys, .rst_b, .pin_in, .pin_out,
    .addr_step_up, .addr_hold, .fg_offset_cal_enable, .background_cal_enable,
    .cal_wr, .trims, .offset_trim_from_regs, .xfer_active, .write_done,
    .write_aborted);
task automatic t_single();
    u_asp_host_model.xfer(1'b0, 15'h0200, 24, 0, 32'hA5, rq);
    u_asp_host_model.xfer(1'b1, 15'h0200, 24, 0, 32'h5A, rq);
    `CHK(trims.bandgap_trim, 8'hA5)
    `CHK(rq[7:0], 8'hA5)
    u_asp_host_model.noise();
    `CHK(trims.bandgap_trim, 8'hA5)
    `CHK(n_active, 392)
    `CHK(n_wdone, 1)
    `CHK(n_abort, 0)
endtask
task automatic t_stream();
    u_asp_host_model.xfer(1'b0, 15'h0208, 32, 0, 32'h1234, rq);
    `CHK(trims.core_offset_trim[0], 16'h1234)
    u_asp_host_model.xfer(1'b1, 15'h0208, 32, 0, 32'h0, rq);
    `CHK(rq[15:0], 16'h1234)
    @(negedge clk_sys);
    addr_step_up = 1'b0;
    u_asp_host_model.xfer(1'b0, 15'h0219, 32, 0, 32'h7856, rq);
    `CHK(trims.core_gain_trim[0], 16'h5678)
    @(negedge clk_sys);
    addr_step_up = 1'b1;
    addr_hold = 1'b1;
    u_asp_host_model.xfer(1'b0, 15'h0230, 32, 0, 32'h2211, rq);
    `CHK(trims.full_scale_adjust, 16'h0022)
    `CHK(n_wdone, 7)
    @(negedge clk_sys);
    addr_hold = 1'b0;
endtask
task automatic t_abort_slow();
    u_asp_host_model.xfer(1'b0, 15'h0201, 20, 0, 32'hFF, rq);
    `CHK(trims.termination_trim[0], 8'h00)
    `CHK(n_abort, 1)
    u_asp_host_model.xfer(1'b0, 15'h0201, 24, 12, 32'h3C, rq);
    `CHK(trims.termination_trim[0], 8'h3C)
    `CHK(n_wdone, 8)
endtask
// Serial traffic is idle while calibration runs
task automatic t_cal();
    @(negedge clk_sys);
    fg_offset_cal_enable = 1'b1;
    background_cal_enable = 1'b1;
    cal_wr = '{1'b1, 3'h2, 16'hBEEF};
    @(negedge clk_sys);
    cal_wr.we = 1'b0;
    @(negedge clk_sys);
    `CHK(trims.core_offset_trim[2], 16'hBEEF)
    `CHK(trims.core_gain_trim[0], 16'h5678)
    `CHK(offset_trim_from_regs, 1'b1)
    background_cal_enable = 1'b0;
    repeat (2) @(negedge clk_sys);
    `CHK(offset_trim_from_regs, 1'b0)
    fg_offset_cal_enable = 1'b0;
endtask
task automatic test_done();
    $display("Checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
        $display("Testbench passed");
    else
        $display("Testbench failed");
    $finish;
endtask
initial
begin
    repeat (16) @(negedge clk_sys);
    rst_b = 1'b1;
    repeat (8) @(negedge clk_sys);
    `CHK(trims, asp_trim_s'(0))
    `CHK(pin_out.serial_data_oe_n, 1'b1)
    t_single();
    t_stream();
    t_abort_slow();
    t_cal();
    test_done();
end
initial
begin
    #200000;
    n_fail++;
    test_done();
end
endmodule // asp_serial_port_tb
bind asp_serial_port asp_serial_port_props u_asp_serial_port_props (.clk_sys,
    .rst_b, .pin_in, .pin_out, .addr_step_up, .addr_hold,
    .fg_offset_cal_enable, .background_cal_enable, .cal_wr, .trims,
    .offset_trim_from_regs, .xfer_active, .write_done, .write_aborted);
